// ### spm_ctrl_map.svh
`ifndef SPM_CTRL_MAP_SVH
`define SPM_CTRL_MAP_SVH
`define SPMC_REG_ADDR     6'h37
`define SPMC_RESET        8'h00
`define SPMC_BIT_IE       7
`define SPMC_BIT_RBUSY    6
`define SPMC_BIT_RSV      5
`define SPMC_BIT_REEN     4
`define SPMC_BIT_LFSEL    3
`define SPMC_BIT_PGWR     2
`define SPMC_BIT_PGER     1
`define SPMC_BIT_EN       0
`define SPMC_CMD_REEN     5'h11
`define SPMC_CMD_LFSEL    5'h09
`define SPMC_CMD_PGWR     5'h05
`define SPMC_CMD_PGER     5'h03
`define SPMC_CMD_LOAD     5'h01
`define SPMC_STORE_WIN    3'h4
`define SPMC_LOAD_WIN     3'h3
`define SPMC_Z_LFUSE      2'h0
`define SPMC_Z_LOCK       2'h1
`define SPMC_Z_EFUSE      2'h2
`define SPMC_Z_HFUSE      2'h3
`define SPMC_WORDS        32
`define SPMC_WIDX_W       5
`endif

// ### spm_ctrl_pkg.sv
package spm_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_BUSY
    } seq_state_t;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_LOAD,
        OP_ERASE,
        OP_WRITE,
        OP_REEN,
        OP_LFSEL
    } op_t;
endpackage

// ### spm_window_timer.sv
`include "spm_ctrl_map.svh"
module spm_window_timer (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic       stop,
    input  wire logic [2:0] limit,
    output logic            expired
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic       run_r;
    logic       run_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        if (start) begin
            cnt_nxt = 3'h1;
            run_nxt = 1'b1;
        end else if (stop) begin
            run_nxt = 1'b0;
        end else if (run_r) begin
            if (cnt_r >= limit) begin
                run_nxt = 1'b0;
            end else begin
                cnt_nxt = cnt_r + 3'h1;
            end
        end
    end

    // expires in the last allowed cycle, the one where cnt_r reaches limit
    assign expired = run_r && !start && !stop && (cnt_r >= limit);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= 3'h0;
            run_r <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
        end
    end
endmodule

// ### spm_ctrl.sv
`include "spm_ctrl_map.svh"
module spm_ctrl (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic [5:0]  IO_ADDR,
    input  wire logic        IO_WE,
    input  wire logic        IO_RE,
    input  wire logic [7:0]  IO_WDATA,
    output logic      [7:0]  IO_RDATA,
    input  wire logic        GLOBAL_IRQ_EN,
    input  wire logic        EEPROM_WRITE_ACTIVE,
    input  wire logic        SPM_EXEC,
    input  wire logic        LPM_EXEC,
    input  wire logic [15:0] Z_PTR,
    input  wire logic [15:0] R1R0,
    input  wire logic [7:0]  LOW_FUSE,
    input  wire logic [7:0]  HIGH_FUSE,
    input  wire logic [7:0]  EXT_FUSE,
    input  wire logic [7:0]  LOCK_BITS,
    input  wire logic        FLASH_DONE,
    output logic             FLASH_ERASE,
    output logic             FLASH_WRITE,
    output logic      [15:0] FLASH_PAGE_ADDR,
    output logic             LF_VALID,
    output logic      [7:0]  LF_DATA,
    output logic             CPU_STALL,
    output logic             PROG_READY_IRQ
);
    spm_ctrl_pkg::seq_state_t st_r, st_nxt;
    spm_ctrl_pkg::op_t        op_r, op_nxt;
    logic [7:0]  ctl_r, ctl_nxt;
    logic        ie_r, ie_nxt;
    logic [15:0] buf_r [`SPMC_WORDS];
    logic [`SPMC_WORDS-1:0] bv_r, bv_nxt;
    logic        fe_r, fe_nxt, fw_r, fw_nxt, stall_r, stall_nxt;
    logic [15:0] pa_r, pa_nxt;
    logic        lfv_r, lfv_nxt, irq_r, irq_nxt;
    logic [7:0]  lfd_r, lfd_nxt, rd_r, rd_nxt;
    logic        wr_hit, cmd_ok, buf_we, win_expired;
    logic [`SPMC_WIDX_W-1:0] widx;

    // fuse store sense is inverted: programmed reads zero
    function automatic logic [7:0] lf_sel(input logic [1:0] z);
        case (z)
            `SPMC_Z_LFUSE: lf_sel = LOW_FUSE;
            `SPMC_Z_LOCK:  lf_sel = LOCK_BITS;
            `SPMC_Z_EFUSE: lf_sel = EXT_FUSE;
            default:       lf_sel = HIGH_FUSE;
        endcase
    endfunction

    assign wr_hit = IO_WE && (IO_ADDR == `SPMC_REG_ADDR);
    assign cmd_ok = (IO_WDATA[4:0] == `SPMC_CMD_REEN)
                 || (IO_WDATA[4:0] == `SPMC_CMD_LFSEL)
                 || (IO_WDATA[4:0] == `SPMC_CMD_PGWR)
                 || (IO_WDATA[4:0] == `SPMC_CMD_PGER)
                 || (IO_WDATA[4:0] == `SPMC_CMD_LOAD);
    assign widx = Z_PTR[`SPMC_WIDX_W:1];
    assign buf_we = (st_r == spm_ctrl_pkg::ST_ARMED) && SPM_EXEC
                 && (op_r == spm_ctrl_pkg::OP_LOAD) && !bv_r[widx];

    spm_window_timer u_win (
        .clk     (CLK_SYS),
        .rst_n   (RST_N),
        .ce      (CE),
        .start   (wr_hit && cmd_ok && !EEPROM_WRITE_ACTIVE
                  && st_r == spm_ctrl_pkg::ST_IDLE),
        .stop    (st_r != spm_ctrl_pkg::ST_ARMED || SPM_EXEC
                  || (op_r == spm_ctrl_pkg::OP_LFSEL && LPM_EXEC)),
        .limit   ((op_r == spm_ctrl_pkg::OP_LFSEL)
                  ? `SPMC_LOAD_WIN : `SPMC_STORE_WIN),
        .expired (win_expired)
    );

    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        ctl_nxt = ctl_r;
        ie_nxt = ie_r;
        bv_nxt = bv_r;
        fe_nxt = 1'b0;
        fw_nxt = 1'b0;
        stall_nxt = stall_r;
        pa_nxt = pa_r;
        lfv_nxt = 1'b0;
        lfd_nxt = lfd_r;
        if (wr_hit) begin
            ie_nxt = IO_WDATA[`SPMC_BIT_IE];
        end
        case (st_r)
            spm_ctrl_pkg::ST_IDLE: begin
                if (wr_hit && cmd_ok && !EEPROM_WRITE_ACTIVE) begin
                    st_nxt = spm_ctrl_pkg::ST_ARMED;
                    ctl_nxt = {3'h0, IO_WDATA[4:0]};
                    case (IO_WDATA[4:0])
                        `SPMC_CMD_REEN:  op_nxt = spm_ctrl_pkg::OP_REEN;
                        `SPMC_CMD_LFSEL: op_nxt = spm_ctrl_pkg::OP_LFSEL;
                        `SPMC_CMD_PGWR:  op_nxt = spm_ctrl_pkg::OP_WRITE;
                        `SPMC_CMD_PGER:  op_nxt = spm_ctrl_pkg::OP_ERASE;
                        default:         op_nxt = spm_ctrl_pkg::OP_LOAD;
                    endcase
                    if (IO_WDATA[4:0] == `SPMC_CMD_REEN) begin
                        bv_nxt = '0;
                    end
                end
            end
            spm_ctrl_pkg::ST_ARMED: begin
                if (op_r == spm_ctrl_pkg::OP_LFSEL && LPM_EXEC) begin
                    lfv_nxt = 1'b1;
                    lfd_nxt = lf_sel(Z_PTR[1:0]);
                    st_nxt = spm_ctrl_pkg::ST_IDLE;
                    ctl_nxt = 8'h00;
                end else if (SPM_EXEC) begin
                    case (op_r)
                        spm_ctrl_pkg::OP_ERASE,
                        spm_ctrl_pkg::OP_WRITE: begin
                            st_nxt = spm_ctrl_pkg::ST_BUSY;
                            stall_nxt = 1'b1;
                            pa_nxt = Z_PTR;
                            fe_nxt = (op_r == spm_ctrl_pkg::OP_ERASE);
                            fw_nxt = (op_r == spm_ctrl_pkg::OP_WRITE);
                        end
                        default: begin
                            st_nxt = spm_ctrl_pkg::ST_IDLE;
                            ctl_nxt = 8'h00;
                            if (buf_we) begin
                                bv_nxt[widx] = 1'b1;
                            end
                        end
                    endcase
                end else if (win_expired) begin
                    st_nxt = spm_ctrl_pkg::ST_IDLE;
                    ctl_nxt = 8'h00;
                end
            end
            spm_ctrl_pkg::ST_BUSY: begin
                if (FLASH_DONE) begin
                    st_nxt = spm_ctrl_pkg::ST_IDLE;
                    stall_nxt = 1'b0;
                    ctl_nxt = 8'h00;
                    if (op_r == spm_ctrl_pkg::OP_WRITE) begin
                        bv_nxt = '0;
                    end
                end
            end
            default: st_nxt = spm_ctrl_pkg::ST_IDLE;
        endcase
        rd_nxt = {ie_nxt, 1'b0, 1'b0, ctl_nxt[4:0]};
        irq_nxt = ie_nxt && GLOBAL_IRQ_EN && !ctl_nxt[`SPMC_BIT_EN]
               && !EEPROM_WRITE_ACTIVE
               && st_nxt == spm_ctrl_pkg::ST_IDLE;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            st_r <= spm_ctrl_pkg::ST_IDLE;
            op_r <= spm_ctrl_pkg::OP_NONE;
            ctl_r <= `SPMC_RESET;
            ie_r <= 1'b0;
            bv_r <= '0;
            fe_r <= 1'b0;
            fw_r <= 1'b0;
            stall_r <= 1'b0;
            pa_r <= 16'h0000;
            lfv_r <= 1'b0;
            lfd_r <= 8'h00;
            rd_r <= `SPMC_RESET;
            irq_r <= 1'b0;
        end else if (CE) begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            ctl_r <= ctl_nxt;
            ie_r <= ie_nxt;
            bv_r <= bv_nxt;
            fe_r <= fe_nxt;
            fw_r <= fw_nxt;
            stall_r <= stall_nxt;
            pa_r <= pa_nxt;
            lfv_r <= lfv_nxt;
            lfd_r <= lfd_nxt;
            rd_r <= rd_nxt;
            irq_r <= irq_nxt;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (CE && buf_we) begin
            buf_r[widx] <= R1R0;
        end
    end

    assign IO_RDATA = rd_r;
    assign FLASH_ERASE = fe_r;
    assign FLASH_WRITE = fw_r;
    assign FLASH_PAGE_ADDR = pa_r;
    assign LF_VALID = lfv_r;
    assign LF_DATA = lfd_r;
    assign CPU_STALL = stall_r;
    assign PROG_READY_IRQ = irq_r;

    property p_rsv_zero;
        @(posedge CLK_SYS) disable iff (!RST_N) IO_RDATA[6:5] == 2'b00;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("bits 6:5 nonzero");
    property p_irq_gate;
        @(posedge CLK_SYS) disable iff (!RST_N)
            PROG_READY_IRQ |-> (ie_r && !ctl_r[`SPMC_BIT_EN]);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");
    property p_irq_ee;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (CE && EEPROM_WRITE_ACTIVE) |=> !PROG_READY_IRQ;
    endproperty
    a_irq_ee: assert property (p_irq_ee) else $error("irq in ee write");
    property p_bad_cmd;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (CE && wr_hit && !cmd_ok && st_r == spm_ctrl_pkg::ST_IDLE)
            |=> st_r == spm_ctrl_pkg::ST_IDLE;
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("bad cmd acted");
    property p_reen_clr;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (CE && wr_hit && IO_WDATA[4:0] == `SPMC_CMD_REEN
             && !EEPROM_WRITE_ACTIVE && st_r == spm_ctrl_pkg::ST_IDLE)
            |=> bv_r == '0;
    endproperty
    a_reen_clr: assert property (p_reen_clr) else $error("buffer kept");
    property p_ee_block;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (CE && wr_hit && EEPROM_WRITE_ACTIVE
             && st_r == spm_ctrl_pkg::ST_IDLE)
            |=> st_r == spm_ctrl_pkg::ST_IDLE;
    endproperty
    a_ee_block: assert property (p_ee_block) else $error("ee not blocking");
    property p_timeout;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (CE && st_r == spm_ctrl_pkg::ST_ARMED && !SPM_EXEC && !LPM_EXEC)
            [*5] |-> st_r != spm_ctrl_pkg::ST_ARMED;
    endproperty
    a_timeout: assert property (p_timeout) else $error("window too long");
    property p_busy_en;
        @(posedge CLK_SYS) disable iff (!RST_N)
            CPU_STALL |-> ctl_r[`SPMC_BIT_EN];
    endproperty
    a_busy_en: assert property (p_busy_en) else $error("en low in op");
    property p_stall_start;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (CE && st_r == spm_ctrl_pkg::ST_ARMED && SPM_EXEC
             && op_r == spm_ctrl_pkg::OP_WRITE)
            |=> CPU_STALL && FLASH_WRITE;
    endproperty
    a_stall_start: assert property (p_stall_start) else $error("no stall");
    property p_stall_end;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (CE && CPU_STALL && FLASH_DONE) |=> !CPU_STALL;
    endproperty
    a_stall_end: assert property (p_stall_end) else $error("stall stuck");
    property p_lf_read;
        @(posedge CLK_SYS) disable iff (!RST_N)
            (CE && st_r == spm_ctrl_pkg::ST_ARMED && LPM_EXEC
             && op_r == spm_ctrl_pkg::OP_LFSEL && Z_PTR[1:0] == 2'h1)
            |=> LF_VALID && LF_DATA == $past(LOCK_BITS);
    endproperty
    a_lf_read: assert property (p_lf_read) else $error("lock read bad");
    c_erase: cover property (@(posedge CLK_SYS) FLASH_ERASE);
    c_write: cover property (@(posedge CLK_SYS) FLASH_WRITE);
    c_lf: cover property (@(posedge CLK_SYS) LF_VALID);
    c_irq: cover property (@(posedge CLK_SYS) PROG_READY_IRQ);
endmodule

// ### flash_timer_model.sv
module flash_timer_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [7:0] lat,
    output logic            done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       run_r;
    logic       run_nxt;
    logic       done_nxt;
    // stands in for the array timer: one done pulse lat+2 cycles after the start cycle
    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        done_nxt = 1'b0;
        if (start) begin
            run_nxt = 1'b1;
            cnt_nxt = lat;
        end else if (run_r && cnt_r == 8'h00) begin
            run_nxt = 1'b0;
            done_nxt = 1'b1;
        end else if (run_r) begin
            cnt_nxt = cnt_r - 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        cnt_r <= rst_n ? cnt_nxt : 8'h00;
        run_r <= rst_n ? run_nxt : 1'b0;
        done <= rst_n ? done_nxt : 1'b0;
    end
endmodule

// ### tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        re = 1'b0;
    logic        we = 1'b0;
    logic        gie = 1'b0;
    logic        ee = 1'b0;
    logic        spm = 1'b0;
    logic        lpm = 1'b0;
    logic [5:0]  addr = 6'h37;
    logic [7:0]  wdata = 8'h00;
    logic [15:0] z = 16'h0000;
    logic [15:0] r1r0 = 16'ha55a;
    logic [7:0]  fz [4] = '{8'h6e, 8'hfc, 8'hf9, 8'hd7};
    logic [7:0]  lat = 8'h02;
    logic [7:0]  rdata;
    logic [7:0]  lfd;
    logic [15:0] pg;
    logic        done;
    logic        f_er;
    logic        f_wr;
    logic        lfv;
    logic        stall;
    logic        irq;
    int          bad_count = 0;
    int          comparisons = 0;

    spm_ctrl i_dut (
        .CLK_SYS(clk), .RST_N(rst_n), .CE(ce), .IO_ADDR(addr),
        .IO_WE(we), .IO_RE(re), .IO_WDATA(wdata), .IO_RDATA(rdata),
        .GLOBAL_IRQ_EN(gie), .EEPROM_WRITE_ACTIVE(ee),
        .SPM_EXEC(spm), .LPM_EXEC(lpm), .Z_PTR(z), .R1R0(r1r0),
        .LOW_FUSE(fz[0]), .HIGH_FUSE(fz[3]), .EXT_FUSE(fz[2]),
        .LOCK_BITS(fz[1]), .FLASH_DONE(done), .FLASH_ERASE(f_er),
        .FLASH_WRITE(f_wr), .FLASH_PAGE_ADDR(pg), .LF_VALID(lfv),
        .LF_DATA(lfd), .CPU_STALL(stall), .PROG_READY_IRQ(irq)
    );
    flash_timer_model i_flash (
        .clk(clk), .rst_n(rst_n), .start(f_er | f_wr), .lat(lat),
        .done(done)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one write strobe at a falling edge, taken at the next rising edge
    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask

    task automatic do_spm();
        spm = 1'b1;
        @(negedge clk);
        spm = 1'b0;
    endtask

    task automatic t_page(input logic [7:0] cmd, input logic is_wr);
        wr(cmd);
        chk("ctl armed", {8'h00, cmd}, rdata);
        z = 16'h1240;
        do_spm();
        for (int i = 0; i < 3 && !(f_wr | f_er); i++) @(negedge clk);
        chk("write start", is_wr, f_wr);
        chk("erase start", !is_wr, f_er);
        chk("page addr", 16'h1240, pg);
        chk("stall", 1'b1, stall);
        chk("busy bit", 1'b1, rdata[0]);
        for (int i = 0; i < 200 && stall; i++) @(negedge clk);
        @(negedge clk);
        chk("stall end", 1'b0, stall);
        chk("ctl done", 16'h0000, rdata);
    endtask

    task automatic t_timeout();
        logic [7:0] c [5] = '{8'h05, 8'h03, 8'h09, 8'h01, 8'h11};
        logic [15:0] w;
        for (int i = 0; i < 5; i++) begin
            wr(c[i]);
            chk("ctl set", {8'h00, c[i]}, rdata);
            w = (c[i] == 8'h09) ? 16'h0000 : {8'h00, c[i]};
            repeat (3) @(negedge clk);
            chk("ctl window", w, rdata);
            repeat (2) @(negedge clk);
            chk("ctl expired", 16'h0000, rdata);
            chk("no stall", 1'b0, stall);
        end
    endtask

    task automatic t_fuse();
        for (int i = 0; i < 4; i++) begin
            wr(8'h09);
            z = 16'(i);
            lpm = 1'b1;
            @(negedge clk);
            lpm = 1'b0;
            for (int k = 0; k < 3 && !lfv; k++) @(negedge clk);
            chk("lf valid", 1'b1, lfv);
            chk("lf data", {8'h00, fz[i]}, lfd);
        end
    endtask

    task automatic t_odd();
        logic [7:0] p [4] = '{8'h07, 8'h1f, 8'h02, 8'h0d};
        for (int i = 0; i < 4; i++) begin
            wr(p[i]);
            chk("odd pattern", 16'h0000, rdata);
            do_spm();
            repeat (2) @(negedge clk);
            chk("odd no stall", 1'b0, stall);
        end
        wr(8'he0);
        chk("bits 6:5", 16'h0080, rdata);
        wr(8'h00);
        addr = 6'h36;
        wr(8'h05);
        addr = 6'h37;
        chk("other addr", 16'h0000, rdata);
    endtask

    task automatic t_eeprom();
        ee = 1'b1;
        wr(8'h05);
        chk("ee blocks write", 16'h0000, rdata);
        do_spm();
        repeat (2) @(negedge clk);
        chk("ee no stall", 1'b0, stall);
        wr(8'h09);
        chk("ee blocks lf", 16'h0000, rdata);
        ee = 1'b0;
    endtask

    task automatic t_buf();
        wr(8'h01);
        do_spm();
        repeat (2) @(negedge clk);
        chk("load clears", 16'h0000, rdata);
        wr(8'h11);
        do_spm();
        repeat (2) @(negedge clk);
        chk("reen clears", 16'h0000, rdata);
    endtask

    task automatic t_ce();
        wr(8'h01);
        ce = 1'b0;
        repeat (6) @(negedge clk);
        chk("ce frozen", 16'h0001, rdata);
        ce = 1'b1;
        repeat (5) @(negedge clk);
        chk("ce resumed", 16'h0000, rdata);
    endtask

    // software side of one timed command: poll, wait eeprom, mask irq
    task automatic cmd(input logic [7:0] c);
        for (int i = 0; i < 300 && rdata[0]; i++) @(negedge clk);
        for (int i = 0; i < 300 && ee; i++) @(negedge clk);
        gie = 1'b0;
        wr(c);
        do_spm();
    endtask

    task automatic t_update();
        z = 16'h0340;
        cmd(8'h03);
        chk("upd erase", 16'h0001, f_er);
        cmd(8'h11);
        for (int k = 0; k < 4; k++) begin
            r1r0 = 16'hc300 + 16'(k);
            cmd(8'h01);
            z = z + 16'h0002;
        end
        z = z - 16'h0008;
        cmd(8'h05);
        chk("upd write", 16'h0001, f_wr);
        chk("upd page", 16'h0340, pg);
        cmd(8'h11);
        for (int i = 0; i < 300 && rdata[0]; i++) @(negedge clk);
        chk("upd idle", 16'h0000, rdata);
    endtask

    task automatic t_irq();
        gie = 1'b1;
        wr(8'h80);
        repeat (2) @(negedge clk);
        chk("irq idle", 1'b1, irq);
        gie = 1'b0;
        repeat (2) @(negedge clk);
        chk("irq gie off", 1'b0, irq);
        gie = 1'b1;
        ee = 1'b1;
        repeat (2) @(negedge clk);
        chk("irq ee", 1'b0, irq);
        ee = 1'b0;
        wr(8'h85);
        chk("irq armed", 1'b0, irq);
        wr(8'h00);
        repeat (6) @(negedge clk);
        chk("irq off", 1'b0, irq);
        gie = 1'b0;
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        chk("reset value", 16'h0000, rdata);
        t_page(8'h03, 1'b0);
        lat = 8'h28;
        t_page(8'h05, 1'b1);
        t_timeout();
        t_fuse();
        t_odd();
        t_eeprom();
        t_buf();
        t_ce();
        t_update();
        t_irq();
        final_report();
    end

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        final_report();
    end
endmodule
